//--- adccs_pkg.sv
// package: register map, field layout, reset values and timing counts of the sequencer
package adccs_pkg;

  // register offsets on the plain register port
  localparam logic [2:0] ADDR_MAIN_CTRL = 3'h0;
  localparam logic [2:0] ADDR_RESULT    = 3'h1;
  localparam logic [2:0] ADDR_PIN_CFG   = 3'h2;
  localparam logic [2:0] ADDR_PORT      = 3'h3;
  localparam logic [2:0] ADDR_IRQ_STAT  = 3'h4;
  localparam logic [2:0] ADDR_IRQ_MASK  = 3'h5;
  localparam logic [2:0] ADDR_DIR       = 3'h6;

  // reset values
  localparam logic [7:0] RST_MAIN_CTRL = 8'h00;
  localparam logic [7:0] RST_RESULT    = 8'h00;
  localparam logic [7:0] RST_PIN_CFG   = 8'h00;
  localparam logic [7:0] RST_DIR       = 8'hFF;
  localparam logic [0:0] RST_IRQ       = 1'h0;

  // irq status / mask bit position
  localparam int IRQ_DONE_BIT = 0;

  // conv_clock_select encodings
  localparam logic [1:0] CS_OSC2  = 2'h0;
  localparam logic [1:0] CS_OSC8  = 2'h1;
  localparam logic [1:0] CS_OSC32 = 2'h2;
  localparam logic [1:0] CS_RC    = 2'h3;

  // oscillator periods per half bit period for each divided source
  localparam logic [3:0] HALF_OSC2  = 4'h1;
  localparam logic [3:0] HALF_OSC8  = 4'h4;
  localparam logic [4:0] HALF_OSC32 = 5'h10;

  // sequence lengths, counted in half bit periods
  localparam logic [4:0] CONV_HALVES  = 5'h13; // 9.5 bit periods
  localparam logic [4:0] WAIT_HALVES  = 5'h04; // 2 bit periods
  localparam logic [4:0] FIRST_DECIDE = 5'h03; // first bit decided here
  localparam logic [4:0] LAST_DECIDE  = 5'h11;

  // main control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] conv_clock_select;
    logic [2:0] input_channel_select;
    logic       go_busy;
    logic       unused_bit;
    logic       converter_power_on;
  } adccs_ctl_type;

  // gray coded sequencer states
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_CONV   = 2'b01,
    ST_WAIT   = 2'b11
  } adccs_state_type;

endpackage

//--- adccs_top.sv
// conversion sequencer: clocking, start/abort, result, done flag and register port
module adccs_top (
  input  wire logic       mclk,          // system clock, 125 MHz
  input  wire logic       resetn,        // asynchronous reset, active low
  input  wire logic [2:0] reg_addr,      // register address
  input  wire logic [7:0] reg_wdata,     // register write data
  input  wire logic       reg_wr,        // write strobe
  input  wire logic       reg_rd,        // read strobe
  output logic      [7:0] reg_rdata,     // read data, cycle after strobe
  input  wire logic       rc_half_tick,  // internal rc clock, one pulse per half bit period
  input  wire logic       comp_high,     // comparator: input at or above trial value
  output logic      [7:0] sar_trial,     // trial code to the comparator dac
  output logic      [2:0] mux_channel,   // analog channel to the hold stage
  output logic            sample_connect,// hold capacitor tied to selected input
  input  wire logic [7:0] pin_level,     // digital levels of the port pins
  output logic      [7:0] pin_dir,       // pin_direction_bits, 1 means input
  output logic            irq            // level interrupt
);

  adccs_pkg::adccs_ctl_type   ctl_q;
  adccs_pkg::adccs_state_type st_q;
  logic [7:0] result_q;
  logic [7:0] pin_cfg_q;   // 1 marks a pin as analog
  logic [7:0] dir_q;
  logic       stat_q;
  logic       mask_q;
  logic [4:0] div_q;
  logic [4:0] hcnt_q;
  logic [7:0] sar_q;
  logic [7:0] bit_q;       // one-hot bit under test
  logic [4:0] fast_cnt_q;  // cycles since an undisturbed start on the fastest source

  logic       wr_ctl;
  logic       start_p;
  logic       abort_p;
  logic       htick;
  logic [4:0] hcnt_next;
  logic       decide;
  logic       done_p;
  logic       wait_end;
  logic [7:0] sar_dec;
  adccs_pkg::adccs_ctl_type wctl;

  // half bit period reload for the divided sources
  function automatic logic [4:0] half_reload(input logic [1:0] cs);
    case (cs)
      adccs_pkg::CS_OSC2:  half_reload = 5'(adccs_pkg::HALF_OSC2) - 5'h01;
      adccs_pkg::CS_OSC8:  half_reload = 5'(adccs_pkg::HALF_OSC8) - 5'h01;
      default:             half_reload = adccs_pkg::HALF_OSC32 - 5'h01;
    endcase
  endfunction

  // write decode and sequencer events
  assign wctl    = adccs_pkg::adccs_ctl_type'(reg_wdata);
  assign wr_ctl  = reg_wr && (reg_addr == adccs_pkg::ADDR_MAIN_CTRL);
  // start only when power was already on, so a combined power-on/start does nothing
  assign start_p = wr_ctl && wctl.go_busy && wctl.converter_power_on
                   && ctl_q.converter_power_on && (st_q == adccs_pkg::ST_SAMPLE);
  assign abort_p = wr_ctl && !wctl.go_busy && wctl.converter_power_on
                   && (st_q == adccs_pkg::ST_CONV);

  // half bit period tick: divider for oscillator sources, rc pulse otherwise
  assign htick = (st_q != adccs_pkg::ST_SAMPLE)
                 && ((ctl_q.conv_clock_select == adccs_pkg::CS_RC) ? rc_half_tick
                                                                  : (div_q == 5'h00));
  assign hcnt_next = hcnt_q + 5'h01;
  // a bit is decided at every odd half period from the third to the seventeenth
  assign decide   = htick && (st_q == adccs_pkg::ST_CONV) && hcnt_next[0]
                    && (hcnt_next >= adccs_pkg::FIRST_DECIDE)
                    && (hcnt_next <= adccs_pkg::LAST_DECIDE);
  assign done_p   = htick && (st_q == adccs_pkg::ST_CONV) && !abort_p
                    && (hcnt_next == adccs_pkg::CONV_HALVES);
  assign wait_end = htick && (st_q == adccs_pkg::ST_WAIT)
                    && (hcnt_next == adccs_pkg::WAIT_HALVES);
  assign sar_dec  = comp_high ? sar_q : (sar_q & ~bit_q);

  // sequencer state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= adccs_pkg::ST_SAMPLE;
    end else if (!ctl_q.converter_power_on) begin
      st_q <= adccs_pkg::ST_SAMPLE;
    end else begin
      case (st_q)
        adccs_pkg::ST_SAMPLE: begin
          if (start_p) begin
            st_q <= adccs_pkg::ST_CONV;
          end
        end
        adccs_pkg::ST_CONV: begin
          if (abort_p || done_p) begin
            st_q <= adccs_pkg::ST_WAIT;
          end
        end
        adccs_pkg::ST_WAIT: begin
          if (wait_end) begin
            st_q <= adccs_pkg::ST_SAMPLE;
          end
        end
        default: st_q <= adccs_pkg::ST_SAMPLE;
      endcase
    end
  end

  // divider and half period counter, restarted on entry to conversion and to wait
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_q  <= 5'h00;
      hcnt_q <= 5'h00;
    end else if (start_p || abort_p || done_p) begin
      div_q  <= half_reload(ctl_q.conv_clock_select);
      hcnt_q <= 5'h00;
    end else if (st_q != adccs_pkg::ST_SAMPLE) begin
      div_q  <= (div_q == 5'h00) ? half_reload(ctl_q.conv_clock_select) : div_q - 5'h01;
      hcnt_q <= htick ? hcnt_next : hcnt_q;
    end
  end

  // successive approximation register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sar_q <= 8'h00;
      bit_q <= 8'h00;
    end else if (start_p) begin
      sar_q <= 8'h80;
      bit_q <= 8'h80;
    end else if (decide) begin
      sar_q <= sar_dec | (bit_q >> 1);
      bit_q <= bit_q >> 1;
    end
  end

  // main control register; hardware clears busy on completion or power-off
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctl_q <= adccs_pkg::adccs_ctl_type'(adccs_pkg::RST_MAIN_CTRL);
    end else if (wr_ctl) begin
      ctl_q            <= wctl;
      ctl_q.unused_bit <= 1'b0;
      // busy only rises on an accepted start; a completion in this cycle still clears it
      ctl_q.go_busy    <= wctl.go_busy
                          && (start_p || ((st_q == adccs_pkg::ST_CONV) && !done_p));
    end else if (done_p || !ctl_q.converter_power_on) begin
      ctl_q.go_busy <= 1'b0;
    end
  end

  // result register: loaded only by completion, or by software
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      result_q <= adccs_pkg::RST_RESULT;
    end else if (done_p) begin
      result_q <= sar_q;
    end else if (reg_wr && reg_addr == adccs_pkg::ADDR_RESULT) begin
      result_q <= reg_wdata;
    end
  end

  // pin configuration and direction registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_cfg_q <= adccs_pkg::RST_PIN_CFG;
      dir_q     <= adccs_pkg::RST_DIR;
    end else if (reg_wr) begin
      if (reg_addr == adccs_pkg::ADDR_PIN_CFG) begin
        pin_cfg_q <= reg_wdata;
      end
      if (reg_addr == adccs_pkg::ADDR_DIR) begin
        dir_q <= reg_wdata;
      end
    end
  end

  // done flag is sticky; a completion in the clearing cycle wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stat_q <= adccs_pkg::RST_IRQ;
      mask_q <= adccs_pkg::RST_IRQ;
    end else begin
      if (done_p) begin
        stat_q <= 1'b1;
      end else if (reg_wr && reg_addr == adccs_pkg::ADDR_IRQ_STAT
                   && reg_wdata[adccs_pkg::IRQ_DONE_BIT]) begin
        stat_q <= 1'b0;
      end
      if (reg_wr && reg_addr == adccs_pkg::ADDR_IRQ_MASK) begin
        mask_q <= reg_wdata[adccs_pkg::IRQ_DONE_BIT];
      end
    end
  end

  // read data, registered for the cycle after the strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        adccs_pkg::ADDR_MAIN_CTRL: reg_rdata <= ctl_q;
        adccs_pkg::ADDR_RESULT:    reg_rdata <= result_q;
        adccs_pkg::ADDR_PIN_CFG:   reg_rdata <= pin_cfg_q;
        adccs_pkg::ADDR_PORT:      reg_rdata <= pin_level & ~pin_cfg_q;
        adccs_pkg::ADDR_IRQ_STAT:  reg_rdata <= {7'h00, stat_q};
        adccs_pkg::ADDR_IRQ_MASK:  reg_rdata <= {7'h00, mask_q};
        adccs_pkg::ADDR_DIR:       reg_rdata <= dir_q;
        default:                   reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // analog side: channel follows the select alone, whatever the pin setup
  assign mux_channel    = ctl_q.input_channel_select;
  assign sample_connect = ctl_q.converter_power_on && (st_q == adccs_pkg::ST_SAMPLE);
  assign sar_trial      = sar_q;
  assign pin_dir        = dir_q;
  assign irq            = stat_q && mask_q;

  // conversion ends exactly at the nineteenth half period
  a_conv_length: assert property (@(posedge mclk) disable iff (!resetn)
    done_p |-> (hcnt_q == 5'h12) && (st_q == adccs_pkg::ST_CONV))
    else $error("conversion did not end after 9.5 bit periods");

  // helper: counts clocks of an undisturbed fast conversion, zero otherwise
  // a counter instead of a long repetition keeps the property cheap for the tools
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fast_cnt_q <= 5'h00;
    end else if (start_p && (ctl_q.conv_clock_select == adccs_pkg::CS_OSC2)) begin
      fast_cnt_q <= 5'h01;
    end else if (wr_ctl || done_p || !ctl_q.converter_power_on) begin
      fast_cnt_q <= 5'h00;
    end else if (fast_cnt_q != 5'h00) begin
      fast_cnt_q <= fast_cnt_q + 5'h01;
    end
  end

  // fastest source: start to done in 19 clocks when left alone
  sequence s_fast_start;
    start_p && (ctl_q.conv_clock_select == adccs_pkg::CS_OSC2);
  endsequence
  // one half period is one clock here, so the half count is also the clock count
  a_fast_timing: assert property (@(posedge mclk) disable iff (!resetn)
    s_fast_start ##19 (fast_cnt_q == adccs_pkg::CONV_HALVES) |-> done_p)
    else $error("2-period source conversion took wrong time");

  // hold stage stays off during the post-conversion wait
  a_wait_isolated: assert property (@(posedge mclk) disable iff (!resetn)
    (st_q == adccs_pkg::ST_WAIT) |-> !sample_connect)
    else $error("hold capacitor connected during wait");

  // abort goes to wait and keeps the result
  a_abort_wait: assert property (@(posedge mclk) disable iff (!resetn)
    abort_p |=> (st_q == adccs_pkg::ST_WAIT) && !ctl_q.go_busy
                && (result_q == $past(result_q)) && (!stat_q || $past(stat_q)))
    else $error("abort did not stop conversion cleanly");

  // after the wait, sampling resumes on its own
  a_resume_sample: assert property (@(posedge mclk) disable iff (!resetn)
    wait_end && ctl_q.converter_power_on && !wr_ctl
    |=> (st_q == adccs_pkg::ST_SAMPLE) && sample_connect)
    else $error("sampling did not resume after wait");

  // completion: flag set, busy clear, result loaded in the same edge
  a_done_effects: assert property (@(posedge mclk) disable iff (!resetn)
    done_p && !wr_ctl |=> stat_q && !ctl_q.go_busy && (result_q == $past(sar_q)))
    else $error("completion effects missing");

  // completion clears busy even when software writes the control register then
  a_busy_clear: assert property (@(posedge mclk) disable iff (!resetn)
    done_p |=> !ctl_q.go_busy)
    else $error("busy bit still set after completion");

  // a start is refused unless power was already on and the sequencer is idle
  a_start_refused: assert property (@(posedge mclk) disable iff (!resetn)
    wr_ctl && wctl.go_busy && !start_p && (st_q != adccs_pkg::ST_CONV)
    |=> !ctl_q.go_busy && (st_q != adccs_pkg::ST_CONV))
    else $error("refused start still set the busy bit");

  // the first trial code is mid-scale, most significant bit first
  a_first_trial: assert property (@(posedge mclk) disable iff (!resetn)
    start_p |=> (sar_trial == 8'h80) && (st_q == adccs_pkg::ST_CONV))
    else $error("conversion did not start at mid-scale");

  // the wait after a conversion or an abort ends at its fourth half period
  a_wait_length: assert property (@(posedge mclk) disable iff (!resetn)
    wait_end |-> (hcnt_q == 5'h03) && (st_q == adccs_pkg::ST_WAIT))
    else $error("post-conversion wait has the wrong length");

  // a running conversion never touches the result before it completes
  a_result_hold: assert property (@(posedge mclk) disable iff (!resetn)
    (st_q == adccs_pkg::ST_CONV) && !done_p
    && !(reg_wr && (reg_addr == adccs_pkg::ADDR_RESULT))
    |=> (result_q == $past(result_q)))
    else $error("result changed during a conversion");

  // at most one bit is under test at any time
  a_bit_onehot: assert property (@(posedge mclk) disable iff (!resetn)
    $onehot0(bit_q))
    else $error("more than one bit under test");

  // read data stands for one cycle only and is zero otherwise
  a_rdata_idle: assert property (@(posedge mclk) disable iff (!resetn)
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data not zero outside the read cycle");

  // analog pins read low on the port
  a_port_analog: assert property (@(posedge mclk) disable iff (!resetn)
    reg_rd && (reg_addr == adccs_pkg::ADDR_PORT) |=> ((reg_rdata & $past(pin_cfg_q)) == 8'h00))
    else $error("analog pin read back non-zero");

  // powered-off converter never leaves sampling idle
  a_power_off: assert property (@(posedge mclk) disable iff (!resetn)
    !ctl_q.converter_power_on |=> (st_q == adccs_pkg::ST_SAMPLE) && !done_p)
    else $error("converter ran while powered off");

  // divider restarts at phase entry
  a_div_reload: assert property (@(posedge mclk) disable iff (!resetn)
    (start_p || done_p) |=> (hcnt_q == 5'h00)
                            && (div_q == half_reload($past(ctl_q.conv_clock_select))))
    else $error("divider not restarted at phase entry");

  // interrupt output mirrors the masked flag
  a_irq_level: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(stat_q) && mask_q |-> irq)
    else $error("interrupt not raised for masked-in flag");

endmodule

//--- tb_top.sv
// self-checking testbench for the conversion sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [1:0] sel;
    logic [2:0] ch;
    logic [7:0] ana;
  } adccs_row_type;

  logic       mclk, resetn, reg_wr, reg_rd, rc_half_tick, comp_high, irq, sample_connect;
  logic [2:0] reg_addr, mux_channel;
  logic [7:0] reg_wdata, reg_rdata, sar_trial, pin_level, pin_dir, ana_level, ctl;
  logic [6:0] rc_cnt;
  int         errors, total_checks, n, h;
  adccs_row_type rows [5];
  localparam int SAMPLE_CYCLES = 1500; // about 12 us of sampling at 8 ns a cycle

  adccs_top DUT (
    .mclk           (mclk),
    .resetn         (resetn),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .rc_half_tick   (rc_half_tick),
    .comp_high      (comp_high),
    .sar_trial      (sar_trial),
    .mux_channel    (mux_channel),
    .sample_connect (sample_connect),
    .pin_level      (pin_level),
    .pin_dir        (pin_dir),
    .irq            (irq)
  );

  // ideal comparator stands in for the analog front end, so the result equals ana_level
  assign comp_high = (ana_level >= sar_trial);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // rc source stand-in: a pulse every 100 cycles gives a 1.6 us bit period
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rc_cnt       <= 7'h00;
      rc_half_tick <= 1'b0;
    end else begin
      rc_cnt       <= (rc_cnt == 7'h63) ? 7'h00 : rc_cnt + 7'h01;
      rc_half_tick <= (rc_cnt == 7'h63);
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  // read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // counts clock edges (or rc pulses in rc mode) until irq or sample_connect goes high
  task automatic wait_units(input logic rc, input logic on_irq, output int cnt);
    logic t;
    int   guard;
    cnt   = 0;
    guard = 0;
    #1;
    while ((on_irq ? irq : sample_connect) !== 1'b1 && guard < 4000) begin
      t = rc_half_tick;
      @(posedge mclk);
      #1;
      guard++;
      if (!rc || t) cnt++;
    end
  endtask

  task automatic final_report;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    #400000;
    errors++;
    final_report;
  end

  initial begin
    resetn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 3'h0; reg_wdata = 8'h00;
    pin_level = 8'h00; ana_level = 8'h00; errors = 0; total_checks = 0;
    rows = '{'{adccs_pkg::CS_OSC2, 3'h6, 8'h00}, '{adccs_pkg::CS_OSC8, 3'h2, 8'h3C},
             '{adccs_pkg::CS_OSC32, 3'h7, 8'hFF}, '{adccs_pkg::CS_OSC2, 3'h5, 8'hA5},
             '{adccs_pkg::CS_RC, 3'h1, 8'h5A}};
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    // reset values and the unmapped address
    rd(adccs_pkg::ADDR_MAIN_CTRL, adccs_pkg::RST_MAIN_CTRL);
    rd(adccs_pkg::ADDR_RESULT, adccs_pkg::RST_RESULT);
    rd(adccs_pkg::ADDR_PIN_CFG, adccs_pkg::RST_PIN_CFG);
    rd(adccs_pkg::ADDR_IRQ_STAT, 8'h00);
    rd(adccs_pkg::ADDR_IRQ_MASK, 8'h00);
    rd(adccs_pkg::ADDR_DIR, adccs_pkg::RST_DIR);
    rd(3'h7, 8'h00);
    chk({8'h00, pin_dir}, {8'h00, adccs_pkg::RST_DIR});
    // analog pins read back low whatever the pin level
    pin_level <= 8'hFF;
    wr(adccs_pkg::ADDR_PIN_CFG, 8'h0F);
    rd(adccs_pkg::ADDR_PORT, 8'hF0);
    // start while powered off, then start together with power-on: both ignored
    wr(adccs_pkg::ADDR_MAIN_CTRL, 8'h04);
    rd(adccs_pkg::ADDR_MAIN_CTRL, 8'h00);
    chk({15'h0000, sample_connect}, 16'h0000);
    wr(adccs_pkg::ADDR_MAIN_CTRL, 8'h00);
    wr(adccs_pkg::ADDR_MAIN_CTRL, 8'h05);
    rd(adccs_pkg::ADDR_MAIN_CTRL, 8'h01);
    wr(adccs_pkg::ADDR_MAIN_CTRL, 8'hC1);
    rd(adccs_pkg::ADDR_MAIN_CTRL, 8'hC1);
    chk({13'h0000, mux_channel}, 16'h0000);
    wr(adccs_pkg::ADDR_IRQ_MASK, 8'h01);
    // ordinary conversions, one per row: every clock select, several channels
    for (int i = 0; i < 5; i++) begin
      ana_level <= rows[i].ana;
      ctl = {rows[i].sel, rows[i].ch, 3'b001};
      case (rows[i].sel)
        adccs_pkg::CS_OSC2:  h = int'(adccs_pkg::HALF_OSC2);
        adccs_pkg::CS_OSC8:  h = int'(adccs_pkg::HALF_OSC8);
        adccs_pkg::CS_OSC32: h = int'(adccs_pkg::HALF_OSC32);
        default:             h = 1;
      endcase
      wr(adccs_pkg::ADDR_DIR, ~rows[i].ana);
      #1;
      chk({8'h00, pin_dir}, {8'h00, ~rows[i].ana});
      wr(adccs_pkg::ADDR_MAIN_CTRL, ctl);
      repeat (SAMPLE_CYCLES) @(posedge mclk);
      wr(adccs_pkg::ADDR_MAIN_CTRL, ctl | 8'h04);
      wait_units(rows[i].sel == adccs_pkg::CS_RC, 1'b1, n);
      chk(16'(n), 16'(int'(adccs_pkg::CONV_HALVES) * h));
      chk({13'h0000, mux_channel}, {13'h0000, rows[i].ch});
      wait_units(rows[i].sel == adccs_pkg::CS_RC, 1'b0, n);
      chk(16'(n), 16'(int'(adccs_pkg::WAIT_HALVES) * h));
      rd(adccs_pkg::ADDR_MAIN_CTRL, ctl);
      rd(adccs_pkg::ADDR_RESULT, rows[i].ana);
      rd(adccs_pkg::ADDR_IRQ_STAT, 8'h01);
      wr(adccs_pkg::ADDR_IRQ_STAT, 8'h01);
      rd(adccs_pkg::ADDR_IRQ_STAT, 8'h00);
      chk({15'h0000, irq}, 16'h0000);
    end
    // analog pins back to inputs for the hand-written cases
    wr(adccs_pkg::ADDR_DIR, 8'hFF);
    // abort in mid-conversion keeps the value software wrote
    wr(adccs_pkg::ADDR_RESULT, 8'h77);
    ana_level <= 8'h12;
    wr(adccs_pkg::ADDR_MAIN_CTRL, 8'h01);
    wr(adccs_pkg::ADDR_MAIN_CTRL, 8'h05);
    repeat (8) @(posedge mclk);
    wr(adccs_pkg::ADDR_MAIN_CTRL, 8'h01);
    wait_units(1'b0, 1'b0, n);
    chk(16'(n), 16'(int'(adccs_pkg::WAIT_HALVES)));
    rd(adccs_pkg::ADDR_RESULT, 8'h77);
    rd(adccs_pkg::ADDR_IRQ_STAT, 8'h00);
    // masked completion: flag set, no interrupt until unmasked
    wr(adccs_pkg::ADDR_IRQ_MASK, 8'h00);
    wr(adccs_pkg::ADDR_MAIN_CTRL, 8'h05);
    repeat (30) @(posedge mclk);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    rd(adccs_pkg::ADDR_IRQ_STAT, 8'h01);
    rd(adccs_pkg::ADDR_RESULT, 8'h12);
    wr(adccs_pkg::ADDR_IRQ_MASK, 8'h01);
    #1;
    chk({15'h0000, irq}, 16'h0001);
    wr(adccs_pkg::ADDR_IRQ_STAT, 8'h01);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    // second reset in mid-run
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd(adccs_pkg::ADDR_MAIN_CTRL, adccs_pkg::RST_MAIN_CTRL);
    chk({8'h00, pin_dir}, {8'h00, adccs_pkg::RST_DIR});
    final_report;
  end
endmodule
